// >>> testbench.sv
// self-checking bench for the mac interface block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import xmi_pkg::*;
  ;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic run = 1'b0;
  logic gmii = 1'b0;
  logic rx_was = 1'b0;
  logic strap_pin = 1'b0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] v, prdata;
  logic [33:0] a;
  xmi_byte_t rx_byte = '0;
  xmi_byte_t cur = '0;
  xmi_byte_t tx_byte;
  xmi_tx_pins_t tx_pins;
  logic [7:0] rxd_pin;
  logic [3:0] tx_skew_sel, rx_skew_sel;
  logic pready, pslverr, rx_clk_pin, rx_ctl_pin, rx_er_pin, mii_tx_clk_pin;
  logic crs_pin, col_pin, rx_take, tx_strobe, lclk;
  logic [33:0] q_apb[$];
  xmi_byte_t q_tx[$];
  logic [5:0] q_rx[$];
  int error_cnt = 0;
  int samples_checked = 0;

  xmi_mac mac (.run, .gmii, .cur, .lclk, .pins(tx_pins));
  xmi_top dut (.clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .strap_pin, .tx_pins, .rx_clk_pin, .rxd_pin, .rx_ctl_pin, .rx_er_pin,
    .mii_tx_clk_pin, .crs_pin, .col_pin, .tx_skew_sel, .rx_skew_sel, .rx_byte, .rx_take,
    .tx_byte, .tx_strobe);

  always #5 clk = ~clk;

  task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task complete_run;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task apb(input logic w, input logic [13:0] ad, input logic [31:0] d, e, input logic er);
    q_apb.push_back({~w, er, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // lock onto the take rhythm first so each note matches its own byte
  // md 0 gigabit reduced-pin, 1 10/100 reduced-pin, 2 mii; one note per falling edge
  task rx_frame(input int n, input int md);
    xmi_byte_t b;
    logic c;
    logic e;
    do
      @(posedge clk);
    while (rx_take !== 1'b1);
    for (int i = 0; i <= n; i++)
    begin
      b = '{data: 8'($urandom), en: i < n, er: i == 2};
      rx_byte <= b;
      do
        @(posedge clk);
      while (rx_take !== 1'b1);
      c = (md == 2) ? b.en : b.en ^ b.er;
      e = (md == 2) && b.er;
      if (md == 0)
        q_rx.push_back({1'b0, c, b.data[7:4]});
      else
        q_rx.push_back({e, c, b.data[3:0]});
      if (md != 0 && b.en)
        q_rx.push_back({e, c, b.data[7:4]});
    end
  endtask

  task tx_frame(input int n);
    xmi_byte_t b;
    run <= 1'b1;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge lclk);
      b = '{data: 8'($urandom), en: i < n, er: i == 1};
      cur <= b;
      if (b.en)
        q_tx.push_back(b);
    end
    repeat (3)
      @(posedge lclk);
    run <= 1'b0;
    // realign to the core clock so the next bus request starts after a rising edge
    @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    rx_was <= rx_clk_pin;
    if (pready === 1'b1 && q_apb.size() > 0)
    begin
      a = q_apb.pop_front();
      chk("pslverr", pslverr, a[32]);
      if (a[33])
        chk("prdata", prdata, a[31:0]);
    end
    if (tx_strobe === 1'b1 && q_tx.size() > 0)
      chk("tx_byte", tx_byte, q_tx.pop_front());
    if (rx_was === 1'b1 && rx_clk_pin === 1'b0 && q_rx.size() > 0)
      chk("rx_fall", {rx_er_pin, rx_ctl_pin, rxd_pin[3:0]}, q_rx.pop_front());
  end

  initial
  begin
    v = $urandom(32'h022a0d15);
    strap_pin <= 1'($urandom);
    repeat (3)
      @(posedge clk);
    srst <= 1'b0;
    repeat (2)
      @(posedge clk);
    apb(1'b0, 14'h0c8, 0, {24'h0, ~strap_pin, 7'h0}, 1'b0);
    apb(1'b1, 14'h1b8, {31'h0, ~strap_pin}, 0, 1'b0);
    apb(1'b0, 14'h1b8, 0, {31'h0, strap_pin}, 1'b0);
    apb(1'b0, 14'h100, 0, 32'h6, 1'b0);
    apb(1'b0, 14'h3fc, 0, 0, 1'b1);
    apb(1'b1, 14'h0c9, v, 0, 1'b1);
    apb(1'b1, 14'h218, v, 0, 1'b0);
    apb(1'b0, 14'h218, 0, {16'h0, v[15:0]}, 1'b0);
    apb(1'b1, 14'h0c8, 32'h83, 0, 1'b0);
    repeat (3)
      @(posedge clk);
    chk("skew", {tx_skew_sel, rx_skew_sel}, v[7:0]);
    apb(1'b1, 14'h0c8, 32'h80, 0, 1'b0);
    repeat (3)
      @(posedge clk);
    chk("skew", {tx_skew_sel, rx_skew_sel}, 0);
    rx_frame(8, 0);
    tx_frame(8);
    apb(1'b1, 14'h0c8, 0, 0, 1'b0);
    gmii <= 1'b1;
    tx_frame(6);
    apb(1'b1, 14'h100, 5, 0, 1'b0);
    rx_frame(4, 2);
    apb(1'b1, 14'h0c8, 32'h80, 0, 1'b0);
    apb(1'b1, 14'h100, 4, 0, 1'b0);
    rx_frame(4, 1);
    apb(1'b1, 14'h0c8, 0, 0, 1'b0);
    apb(1'b1, 14'h100, 1, 0, 1'b0);
    cur <= '{data: 8'h55, en: 1'b1, er: 1'b0};
    run <= 1'b1;
    rx_byte <= '{data: 8'($urandom), en: 1'b1, er: 1'b0};
    for (int i = 0; i < 300 && col_pin !== 1'b1; i++)
      @(posedge clk);
    chk("col", {col_pin, crs_pin}, 2'b11);
    apb(1'b1, 14'h100, 5, 0, 1'b0);
    rx_byte <= '0;
    repeat (100)
      @(posedge clk);
    chk("col_crs", {col_pin, crs_pin}, 0);
    cur <= '0;
    // second reset with the other strap level
    strap_pin <= ~strap_pin;
    srst <= 1'b1;
    repeat (3)
      @(posedge clk);
    srst <= 1'b0;
    repeat (2)
      @(posedge clk);
    apb(1'b0, 14'h0c8, 0, {24'h0, ~strap_pin, 7'h0}, 1'b0);
    apb(1'b0, 14'h1b8, 0, {31'h0, strap_pin}, 1'b0);
    chk("left", q_tx.size() + q_rx.size(), 0);
    complete_run;
  end

  initial
  begin
    #200000;
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire

// >>> xmi_mac.sv
// mac-side model that drives the transmit pins
`timescale 1ns/1ps
`default_nettype none
module xmi_mac
  import xmi_pkg::*;
(
  input wire logic run,
  input wire logic gmii,
  input wire xmi_byte_t cur,
  output logic lclk,
  output xmi_tx_pins_t pins
);
  xmi_byte_t b = '0;
  initial
    lclk = 1'b0;
  // held low until speed agreed; stops only after a full high phase
  always #40 lclk = (run | lclk) & ~lclk;
  always @(posedge lclk) b = cur;
  // unused upper lines carry the inverse so stale values never look valid
  always_comb
  begin
    pins.clk = lclk;
    pins.er = gmii & b.er;
    pins.ctl = (gmii | lclk) ? b.en : b.en ^ b.er;
    pins.d = gmii ? b.data : {~b.data[7:4], lclk ? b.data[3:0] : b.data[7:4]};
  end
endmodule
`default_nettype wire

// >>> xmi_map.svh
// register indices, field positions, reset values and timing counts of the mac interface block
`ifndef XMI_MAP_SVH
`define XMI_MAP_SVH
`define XMI_IDX_RIC 12'h032
`define XMI_IDX_DLY 12'h086
`define XMI_IDX_STRAP 12'h06e
`define XMI_IDX_LINK 12'h040
`define XMI_RIC_RGMII_EN 7
`define XMI_RIC_TX_SHIFT 1
`define XMI_RIC_RX_SHIFT 0
`define XMI_DLY_TX_LSB 4
`define XMI_DLY_RX_LSB 0
`define XMI_STRAP_BIT 0
`define XMI_LINK_FDX 2
`define XMI_LINK_CRS 4
`define XMI_LINK_COL 5
`define XMI_LINK_TX_ACT 6
`define XMI_LINK_RX_ACT 7
`define XMI_RIC_RST 16'h0000
`define XMI_DLY_RST 16'h0000
`define XMI_LINK_RST 16'h0006
`define XMI_SPD_10 2'h0
`define XMI_SPD_100 2'h1
`define XMI_SPD_1000 2'h2
`define XMI_SKEW_STEP_PS 250
`define XMI_CLK_PERIOD_PS 10000
`define XMI_HALF_PS_10 200000
`define XMI_HALF_PS_100 20000
`define XMI_HALF_PS_1000 4000
`define XMI_HALF_CYC_10 (`XMI_HALF_PS_10 / `XMI_CLK_PERIOD_PS)
`define XMI_HALF_CYC_100 (`XMI_HALF_PS_100 / `XMI_CLK_PERIOD_PS)
`define XMI_HALF_CYC_1000 (`XMI_HALF_PS_1000 / `XMI_CLK_PERIOD_PS)
`endif

// >>> xmi_pkg.sv
// types shared by the mac interface block
package xmi_pkg;
  typedef enum logic [1:0] {XMI_RGMII_GIG, XMI_RGMII_NIB, XMI_GMII, XMI_MII} xmi_mode_t;
  typedef struct packed {
    logic [7:0] data;
    logic en;
    logic er;
  } xmi_byte_t;
  typedef struct packed {
    logic clk;
    logic [7:0] d;
    logic ctl;
    logic er;
  } xmi_tx_pins_t;
endpackage

// >>> xmi_top.sv
// mac-facing rgmii / gmii / mii data interface with apb register access
// Behaviour
// - interface-select bit 7 of reduced_interface_control: 1 reduced-pin, 0 gmii
// - that bit loads its reset value from the rgmii-disable strap level
// - the sampled strap value reads back in strap_status_first
// - reduced-pin clocks run at gigabit, 100 or 10 rates by speed; at gigabit the receive clock runs at half the core clock
// - gigabit reduced-pin: low nibble on rising edge, high nibble on falling
// - control line: enable on rising edge, error-related value on falling edge
// - receive control high both edges in frame, low both edges when idle
// - separate transmit and receive skew, sixteen settings each
// - aligned mode adds no skew; shift mode uses delay control in quarter-ns steps
// - at 10/100 reduced-pin, mac makes transmit clock, device makes receive clock
// - receive clock phases may stretch on speed change
// - no clock glitches during speed changes
// - at 10/100 reduced-pin the rising nibble may repeat on falling edge
// - gmii carries separate 8-bit paths synchronous to their clocks
// - gmii configuration carries 10/100 traffic over nibble mii signals
// - mii receive: 4-bit data, valid and error on a 2.5 or 25 MHz clock
// - mii transmit: mac gives 4-bit data and enable on transmit clock
// - carrier sense while receiving, and in half duplex while transmitting
// - collision in half duplex when transmit and receive overlap
// - no collision in full duplex
// - full duplex carrier sense follows receive activity only
// - carrier sense drops at end of packet
`timescale 1ns/1ps
`default_nettype none
`include "xmi_map.svh"
module xmi_top
  import xmi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [13:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic strap_pin,
  input wire xmi_tx_pins_t tx_pins,
  output logic rx_clk_pin,
  output logic [7:0] rxd_pin,
  output logic rx_ctl_pin,
  output logic rx_er_pin,
  output logic mii_tx_clk_pin,
  output logic crs_pin,
  output logic col_pin,
  output logic [3:0] tx_skew_sel,
  output logic [3:0] rx_skew_sel,
  input wire xmi_byte_t rx_byte,
  output logic rx_take,
  output xmi_byte_t tx_byte,
  output logic tx_strobe
);

  function automatic logic [5:0] half_of(input logic [1:0] spd);
    int cyc;
    cyc = (spd == `XMI_SPD_10) ? `XMI_HALF_CYC_10 :
          (spd == `XMI_SPD_100) ? `XMI_HALF_CYC_100 : `XMI_HALF_CYC_1000;
    if (cyc < 1)
    begin
      cyc = 1;
    end
    return 6'(cyc);
  endfunction

  function automatic xmi_mode_t mode_of(input logic rgmii, input logic [1:0] spd);
    logic gig;
    gig = (spd != `XMI_SPD_10) && (spd != `XMI_SPD_100);
    if (rgmii)
    begin
      return gig ? XMI_RGMII_GIG : XMI_RGMII_NIB;
    end
    return gig ? XMI_GMII : XMI_MII;
  endfunction

  logic [15:0] ric;
  logic [15:0] dly;
  logic [15:0] link;
  logic strap_val;
  logic strap_done;
  logic strap_s1;
  logic strap_s2;
  xmi_tx_pins_t tx_s1;
  xmi_tx_pins_t tx_s2;
  logic gtx_prev;
  logic [11:0] idx;
  logic hit;
  logic wr_en;
  logic [31:0] rd_word;
  logic [5:0] half_cnt;
  logic [1:0] act_speed;
  logic rx_rise;
  logic rx_fall;
  xmi_mode_t rx_mode;
  xmi_mode_t tx_mode;
  xmi_byte_t rx_cur;
  logic rx_nib_hi;
  logic t_rise;
  logic t_fall;
  logic [3:0] tx_lo;
  logic [3:0] tx_cur;
  logic tx_ctl_r;
  logic tx_nib_hi;
  logic tx_er_lo;
  logic tx_act;
  logic nib_ev;
  logic [3:0] nib_val;
  logic nib_en;
  logic nib_er;

  // two-stage synchronisers; left unreset so the strap is already settled when reset ends
  always_ff @(posedge clk)
  begin
    strap_s1 <= strap_pin;
    strap_s2 <= strap_s1;
    tx_s1 <= tx_pins;
    tx_s2 <= tx_s1;
  end

  // apb slave: zero-wait access phase, error on unmapped or misaligned word
  assign idx = paddr[13:2];
  assign hit = (paddr[1:0] == 2'h0) && ((idx == `XMI_IDX_RIC) || (idx == `XMI_IDX_DLY)
               || (idx == `XMI_IDX_STRAP) || (idx == `XMI_IDX_LINK));
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_comb
  begin
    rd_word = 32'h0;
    unique case (idx)
      `XMI_IDX_RIC: rd_word[15:0] = ric;
      `XMI_IDX_DLY: rd_word[15:0] = dly;
      `XMI_IDX_STRAP: rd_word[`XMI_STRAP_BIT] = strap_val;
      `XMI_IDX_LINK:
      begin
        rd_word[15:0] = link;
        rd_word[`XMI_LINK_CRS] = crs_pin;
        rd_word[`XMI_LINK_COL] = col_pin;
        rd_word[`XMI_LINK_TX_ACT] = tx_act;
        rd_word[`XMI_LINK_RX_ACT] = rx_byte.en;
      end
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= !hit;
      prdata <= hit ? rd_word : 32'h0;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control registers; the strap is caught on the first cycle after reset release
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ric <= `XMI_RIC_RST;
      dly <= `XMI_DLY_RST;
      link <= `XMI_LINK_RST;
      strap_val <= 1'b0;
      strap_done <= 1'b0;
    end
    else
    begin
      if (!strap_done)
      begin
        strap_val <= strap_s2;
        ric[`XMI_RIC_RGMII_EN] <= !strap_s2;
        strap_done <= 1'b1;
      end
      else if (wr_en && idx == `XMI_IDX_RIC)
      begin
        ric <= pwdata[15:0];
      end
      if (wr_en && idx == `XMI_IDX_DLY)
      begin
        dly <= pwdata[15:0];
      end
      if (wr_en && idx == `XMI_IDX_LINK)
      begin
        link <= {13'h0, pwdata[2:0]};
      end
    end
  end

  // skew taps for the pad delay cells, one step is XMI_SKEW_STEP_PS
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_skew_sel <= 4'h0;
      rx_skew_sel <= 4'h0;
    end
    else
    begin
      tx_skew_sel <= ric[`XMI_RIC_TX_SHIFT] ? dly[`XMI_DLY_TX_LSB +: 4] : 4'h0;
      rx_skew_sel <= ric[`XMI_RIC_RX_SHIFT] ? dly[`XMI_DLY_RX_LSB +: 4] : 4'h0;
    end
  end

  // receive clock divider; gigabit is scaled down since the core clock cannot reach it
  assign rx_rise = (half_cnt == half_of(act_speed) - 6'h1) && !rx_clk_pin;
  assign rx_fall = (half_cnt == half_of(act_speed) - 6'h1) && rx_clk_pin;
  assign rx_mode = mode_of(ric[`XMI_RIC_RGMII_EN], act_speed);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      half_cnt <= 6'h0;
      rx_clk_pin <= 1'b0;
      act_speed <= `XMI_SPD_1000;
    end
    else if (rx_rise || rx_fall)
    begin
      half_cnt <= 6'h0;
      rx_clk_pin <= !rx_clk_pin;
      // speed only changes as a high phase ends, so phases stretch but never split
      if (rx_fall)
      begin
        act_speed <= link[1:0];
      end
    end
    else
    begin
      half_cnt <= half_cnt + 6'h1;
    end
  end

  // mii transmit clock is sourced here, same divider one cycle behind
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mii_tx_clk_pin <= 1'b0;
    end
    else
    begin
      mii_tx_clk_pin <= (rx_mode == XMI_MII) && rx_clk_pin;
    end
  end

  // receive data path toward the mac
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rxd_pin <= 8'h0;
      rx_ctl_pin <= 1'b0;
      rx_er_pin <= 1'b0;
      rx_cur <= '0;
      rx_nib_hi <= 1'b0;
      rx_take <= 1'b0;
    end
    else
    begin
      rx_take <= 1'b0;
      if (rx_rise)
      begin
        unique case (rx_mode)
          XMI_RGMII_GIG:
          begin
            rx_cur <= rx_byte;
            rx_take <= 1'b1;
            rxd_pin <= {4'h0, rx_byte.data[3:0]};
            rx_ctl_pin <= rx_byte.en;
            rx_er_pin <= 1'b0;
          end
          XMI_GMII:
          begin
            rx_take <= 1'b1;
            rxd_pin <= rx_byte.data;
            rx_ctl_pin <= rx_byte.en;
            rx_er_pin <= rx_byte.er;
          end
          XMI_RGMII_NIB, XMI_MII:
          begin
            // low nibble first, high nibble on the next clock
            if (!rx_nib_hi)
            begin
              rx_cur <= rx_byte;
              rx_take <= 1'b1;
              rx_nib_hi <= rx_byte.en;
              rxd_pin <= {4'h0, rx_byte.data[3:0]};
              rx_ctl_pin <= rx_byte.en;
              rx_er_pin <= (rx_mode == XMI_MII) && rx_byte.er;
            end
            else
            begin
              rx_nib_hi <= 1'b0;
              rxd_pin <= {4'h0, rx_cur.data[7:4]};
              rx_ctl_pin <= rx_cur.en;
              rx_er_pin <= (rx_mode == XMI_MII) && rx_cur.er;
            end
          end
        endcase
      end
      else if (rx_fall)
      begin
        if (rx_mode == XMI_RGMII_GIG)
        begin
          rxd_pin <= {4'h0, rx_cur.data[7:4]};
          rx_ctl_pin <= rx_cur.en ^ rx_cur.er;
        end
        else if (rx_mode == XMI_RGMII_NIB)
        begin
          // nibble stays on the pins: repeated on the falling edge
          rx_ctl_pin <= rx_cur.en ^ rx_cur.er;
        end
      end
    end
  end

  // transmit edges: own clock for mii, mac clock otherwise; mac clock edges lag the pins by two cycles, the mii edge is rx_rise, a cycle before rx_clk_pin rises
  assign tx_mode = mode_of(ric[`XMI_RIC_RGMII_EN], act_speed);
  assign t_rise = (tx_mode == XMI_MII) ? rx_rise : (tx_s2.clk && !gtx_prev);
  assign t_fall = (tx_mode == XMI_MII) ? 1'b0 : (!tx_s2.clk && gtx_prev);

  // one nibble source for both nibble modes
  always_comb
  begin
    if (tx_mode == XMI_MII)
    begin
      nib_ev = t_rise;
      nib_val = tx_s2.d[3:0];
      nib_en = tx_s2.ctl;
      nib_er = tx_s2.er;
    end
    else
    begin
      nib_ev = t_fall && (tx_mode == XMI_RGMII_NIB);
      nib_val = tx_cur;
      nib_en = tx_ctl_r;
      nib_er = tx_ctl_r ^ tx_s2.ctl;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      gtx_prev <= 1'b0;
      tx_lo <= 4'h0;
      tx_cur <= 4'h0;
      tx_ctl_r <= 1'b0;
      tx_nib_hi <= 1'b0;
      tx_er_lo <= 1'b0;
      tx_act <= 1'b0;
      tx_byte <= '0;
      tx_strobe <= 1'b0;
    end
    else
    begin
      gtx_prev <= tx_s2.clk;
      tx_strobe <= 1'b0;
      if (t_rise && tx_mode != XMI_MII)
      begin
        tx_cur <= tx_s2.d[3:0];
        tx_ctl_r <= tx_s2.ctl;
      end
      if (t_rise && tx_mode == XMI_GMII)
      begin
        tx_byte <= '{data: tx_s2.d, en: tx_s2.ctl, er: tx_s2.er};
        tx_strobe <= tx_s2.ctl || tx_s2.er;
        tx_act <= tx_s2.ctl;
      end
      if (t_fall && tx_mode == XMI_RGMII_GIG)
      begin
        tx_byte <= '{data: {tx_s2.d[3:0], tx_cur}, en: tx_ctl_r,
                     er: tx_ctl_r ^ tx_s2.ctl};
        tx_strobe <= tx_ctl_r || (tx_ctl_r ^ tx_s2.ctl);
        tx_act <= tx_ctl_r;
      end
      if (nib_ev)
      begin
        tx_act <= nib_en;
        if (!nib_en)
        begin
          tx_nib_hi <= 1'b0;
        end
        else if (!tx_nib_hi)
        begin
          tx_lo <= nib_val;
          tx_er_lo <= nib_er;
          tx_nib_hi <= 1'b1;
        end
        else
        begin
          tx_byte <= '{data: {nib_val, tx_lo}, en: 1'b1, er: nib_er || tx_er_lo};
          tx_strobe <= 1'b1;
          tx_nib_hi <= 1'b0;
        end
      end
    end
  end

  // media status; rx_byte.en is the receive frame level from the line side
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      crs_pin <= 1'b0;
      col_pin <= 1'b0;
    end
    else
    begin
      crs_pin <= rx_byte.en || (!link[`XMI_LINK_FDX] && tx_act);
      col_pin <= !link[`XMI_LINK_FDX] && rx_byte.en && tx_act;
    end
  end

endmodule
`default_nettype wire

// >>> xmi_top_props.sv
// assertions on the ports of the mac interface block
`timescale 1ns/1ps
`default_nettype none
module xmi_chk
  import xmi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire xmi_byte_t rx_byte,
  input wire logic rx_take,
  input wire logic rx_clk_pin,
  input wire logic [7:0] rxd_pin,
  input wire logic rx_ctl_pin,
  input wire logic mii_tx_clk_pin,
  input wire logic crs_pin,
  input wire logic col_pin,
  input wire logic [3:0] tx_skew_sel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not single after setup");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error without ready or with data");
  property p_lo;
    rx_take |-> rxd_pin[3:0] == $past(rx_byte.data[3:0]);
  endproperty
  a_lo: assert property (p_lo) else $error("low nibble not on taking edge");
  property p_ctl;
    rx_take |-> rx_ctl_pin == $past(rx_byte.en);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control not enable on rise");
  property p_crs;
    rx_byte.en |=> crs_pin;
  endproperty
  a_crs: assert property (p_crs) else $error("carrier missing on receive");
  property p_crs_end;
    $fell(crs_pin) |-> !$past(rx_byte.en);
  endproperty
  a_crs_end: assert property (p_crs_end) else $error("carrier dropped in packet");
  property p_col;
    col_pin |-> $past(rx_byte.en) && crs_pin;
  endproperty
  a_col: assert property (p_col) else $error("collision without receive");
  property p_txclk;
    mii_tx_clk_pin |-> $past(rx_clk_pin);
  endproperty
  a_txclk: assert property (p_txclk) else $error("transmit clock not delayed copy");
  // the transmit skew tap may only move after a register write lands
  property p_skew;
    $changed(tx_skew_sel) |-> $past(pwrite && pready) || $past(pwrite && pready, 2);
  endproperty
  a_skew: assert property (p_skew) else $error("skew moved without write");
  cover property (pslverr);
  cover property (col_pin);
  cover property (rx_take ##2 rx_take);
endmodule
bind xmi_top xmi_chk u_chk (.clk, .srst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .rx_byte, .rx_take, .rx_clk_pin, .rxd_pin, .rx_ctl_pin, .mii_tx_clk_pin, .crs_pin,
  .col_pin, .tx_skew_sel);
`default_nettype wire
